// ===== div_counter.sv
// Programmable down counter used for the reference and feedback dividers
`timescale 1ns/1ns
module div_counter #(
    parameter int WIDTH = 14
) (
    input  wire logic               core_clk,
    input  wire logic               nrst,
    input  wire logic               ce,
    input  wire logic               hold,
    input  wire logic               tick,
    input  wire logic [WIDTH-1:0]   load_val,
    output logic      [WIDTH-1:0]   count,
    output logic                    term
);

    // ========================================================
    // Counting
    logic               fresh;
    logic               at_end;
    logic [WIDTH-1:0]   next_count;

    // A value of zero or one divides by one
    assign at_end     = (count <= WIDTH'(1));
    assign next_count = count - WIDTH'(1);

    // Held counter follows load_val; first tick after release reloads
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
            fresh <= 1'b1;
            term  <= 1'b0;
        end else if (ce) begin
            term <= 1'b0;
            if (hold) begin
                count <= load_val;
                fresh <= 1'b1;
            end else if (tick && fresh) begin
                count <= load_val;
                fresh <= 1'b0;
            end else if (tick && at_end) begin
                count <= load_val;
                term  <= 1'b1;
            end else if (tick) begin
                count <= next_count;
            end
        end
    end

endmodule

// ===== pll_cfg_pkg.sv
// Package: register map, field positions and codes of the divider block
package pll_cfg_pkg;

    // ========================================================
    // Register port geometry
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;

    // ========================================================
    // Register offsets
    localparam logic [9:0] PLL_CTRL_OFS     = 10'h010;
    localparam logic [9:0] REF_LOW_OFS      = 10'h011;
    localparam logic [9:0] REF_HIGH_OFS     = 10'h012;
    localparam logic [9:0] SWALLOW_OFS      = 10'h013;
    localparam logic [9:0] MAIN_LOW_OFS     = 10'h014;
    localparam logic [9:0] MAIN_HIGH_OFS    = 10'h015;
    localparam logic [9:0] RST_PUMP_OFS     = 10'h016;

    // ========================================================
    // Reset values
    localparam logic [7:0] PLL_CTRL_RST     = 8'h7D;
    localparam logic [7:0] REF_LOW_RST      = 8'h01;
    localparam logic [5:0] REF_HIGH_RST     = 6'h00;
    localparam logic [5:0] SWALLOW_RST      = 6'h00;
    localparam logic [7:0] MAIN_LOW_RST     = 8'h03;
    localparam logic [4:0] MAIN_HIGH_RST    = 5'h00;
    localparam logic [7:0] RST_PUMP_RST     = 8'h00;

    // ========================================================
    // Field widths and positions
    localparam int REF_W            = 14;
    localparam int SWALLOW_W        = 6;
    localparam int MAIN_W           = 13;
    localparam int PUMP_HALF_BIT    = 7;
    localparam int REF_RESET_BIT    = 6;
    localparam int FB_RESET_BIT     = 5;
    localparam int ALL_RESET_BIT    = 4;

    // ========================================================
    // Operating mode codes, field [1:0] of the mode register
    localparam logic [1:0] MODE_NORMAL      = 2'h0;
    localparam logic [1:0] MODE_SYNC_PD     = 2'h1;
    localparam logic [1:0] MODE_UNUSED      = 2'h2;
    localparam logic [1:0] MODE_ASYNC_PD    = 2'h3;

endpackage

// ===== pll_divider_counter_config.sv
// Divider count registers, counter reset and pump control of the PLL
`timescale 1ns/1ns
module pll_divider_counter_config
    import pll_cfg_pkg::*;
(
    input  wire logic                           core_clk,
    input  wire logic                           nrst,
    input  wire logic                           ce,
    input  wire logic [pll_cfg_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [pll_cfg_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [pll_cfg_pkg::DATA_W-1:0] reg_rdata,
    output logic                                reg_rvalid,
    input  wire logic                           ref_clk_pin,
    input  wire logic                           fb_clk_pin,
    output logic                                ref_div_pulse,
    output logic                                fb_div_pulse,
    output logic                                swallow_pulse,
    output logic                                pump_force_half,
    output logic                                ref_in_reset,
    output logic                                fb_in_reset,
    output logic                                pll_active,
    output logic                                sync_power_down,
    output logic                                async_power_down
);
    import pll_cfg_pkg::*;

    // ========================================================
    // Register storage
    logic [7:0]             pll_mode_ctrl;
    logic [7:0]             ref_divider_low;
    logic [5:0]             ref_divider_high;
    logic [5:0]             swallow_count;
    logic [7:0]             main_feedback_count_low;
    logic [4:0]             main_feedback_count_high;
    logic [7:0]             divider_reset_pump_control;

    // Offset compare shared by the write and the read decode
    function automatic logic addr_is(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] ofs
    );
        return addr == ofs;
    endfunction

    // Address decode; offsets outside the map match nothing
    wire  hit_mode    = addr_is(reg_addr, PLL_CTRL_OFS);
    wire  hit_ref_lo  = addr_is(reg_addr, REF_LOW_OFS);
    wire  hit_ref_hi  = addr_is(reg_addr, REF_HIGH_OFS);
    wire  hit_swallow = addr_is(reg_addr, SWALLOW_OFS);
    wire  hit_main_lo = addr_is(reg_addr, MAIN_LOW_OFS);
    wire  hit_main_hi = addr_is(reg_addr, MAIN_HIGH_OFS);
    wire  hit_ctrl    = addr_is(reg_addr, RST_PUMP_OFS);
    wire  wr_en       = ce && reg_wr;

    // Writes land on the same edge they are presented. Spare upper bits
    // of the short registers are dropped here rather than stored, so no
    // stale spare bit can ever reach a counter load value.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pll_mode_ctrl              <= PLL_CTRL_RST;
            ref_divider_low            <= REF_LOW_RST;
            ref_divider_high           <= REF_HIGH_RST;
            swallow_count              <= SWALLOW_RST;
            main_feedback_count_low    <= MAIN_LOW_RST;
            main_feedback_count_high   <= MAIN_HIGH_RST;
            divider_reset_pump_control <= RST_PUMP_RST;
        end else if (wr_en) begin
            if (hit_mode) begin
                pll_mode_ctrl <= reg_wdata;
            end
            if (hit_ref_lo) begin
                ref_divider_low <= reg_wdata;
            end
            if (hit_ref_hi) begin
                ref_divider_high <= reg_wdata[5:0];
            end
            if (hit_swallow) begin
                swallow_count <= reg_wdata[5:0];
            end
            if (hit_main_lo) begin
                main_feedback_count_low <= reg_wdata;
            end
            if (hit_main_hi) begin
                main_feedback_count_high <= reg_wdata[4:0];
            end
            if (hit_ctrl) begin
                divider_reset_pump_control <= reg_wdata;
            end
        end
    end

    // ========================================================
    // Read path; unmapped offsets and unused upper bits read zero
    logic [7:0]         read_mux;
    logic [7:0]         rb_ref_high;
    logic [7:0]         rb_swallow;
    logic [7:0]         rb_main_high;

    // Short registers padded to a byte for readback
    assign rb_ref_high  = {2'h0, ref_divider_high};
    assign rb_swallow   = {2'h0, swallow_count};
    assign rb_main_high = {3'h0, main_feedback_count_high};

    assign read_mux =
        hit_mode    ? pll_mode_ctrl :
        hit_ref_lo  ? ref_divider_low :
        hit_ref_hi  ? rb_ref_high :
        hit_swallow ? rb_swallow :
        hit_main_lo ? main_feedback_count_low :
        hit_main_hi ? rb_main_high :
        hit_ctrl    ? divider_reset_pump_control :
                      8'h00;

    // Read data registered, valid one cycle after the strobe. The mux
    // looks at storage before the edge, so a write and a read to one
    // offset in the same cycle return the old value.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= read_mux;
            end
        end
    end

    // ========================================================
    // Mode and counter-reset decode
    logic [1:0]         mode_code;
    logic               mode_normal;
    logic               next_ref_hold;
    logic               next_fb_hold;
    logic               next_pump_half;
    logic               next_sync_pd;
    logic               next_async_pd;

    // All-counters bit in both groups
    // The all-counters bit and any mode but normal override a group's own
    // bit, so a powered-down PLL never leaves a divider running free
    function automatic logic counter_held(
        input logic [7:0] ctrl,
        input int         own_bit,
        input logic       normal
    );
        return ctrl[own_bit] || ctrl[ALL_RESET_BIT] || !normal;
    endfunction

    // Only the mode field matters here; pump current, pump mode and
    // polarity bits are kept for readback alone
    assign mode_code   = pll_mode_ctrl[1:0];
    assign mode_normal = (mode_code == MODE_NORMAL);

    assign next_ref_hold =
        counter_held(divider_reset_pump_control, REF_RESET_BIT, mode_normal);

    // Swallow and main hold, bit 5
    assign next_fb_hold =
        counter_held(divider_reset_pump_control, FB_RESET_BIT, mode_normal);

    assign next_pump_half = divider_reset_pump_control[PUMP_HALF_BIT];

    // Power-down codes; unused 10 raises neither flag
    assign next_sync_pd  = (mode_code == MODE_SYNC_PD);
    assign next_async_pd = (mode_code == MODE_ASYNC_PD);

    // Status outputs all come from flops, one cycle behind storage
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pump_force_half  <= 1'b0;
            ref_in_reset     <= 1'b1;
            fb_in_reset      <= 1'b1;
            pll_active       <= 1'b0;
            sync_power_down  <= 1'b1;
            async_power_down <= 1'b0;
        end else if (ce) begin
            pump_force_half  <= next_pump_half;
            ref_in_reset     <= next_ref_hold;
            fb_in_reset      <= next_fb_hold;
            pll_active       <= mode_normal;
            sync_power_down  <= next_sync_pd;
            async_power_down <= next_async_pd;
        end
    end

    // ========================================================
    // Pin synchronisers and edge detect
    logic [2:0]         ref_sync;
    logic [2:0]         fb_sync;
    logic               ref_tick;
    logic               fb_tick;

    // Pins are asynchronous: two stages settle them, the third keeps the
    // previous settled level for edge detection. Logic reads only the
    // second and third stages, never the first.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ref_sync <= 3'h0;
            fb_sync  <= 3'h0;
        end else if (ce) begin
            ref_sync <= {ref_sync[1:0], ref_clk_pin};
            fb_sync  <= {fb_sync[1:0], fb_clk_pin};
        end
    end

    // Rising edge between settled and previous levels
    function automatic logic rose(input logic [1:0] stages);
        return stages[0] && !stages[1];
    endfunction

    // Pin clocks must stay below half of core_clk or edges are lost;
    // the tick trails the pin edge by about two core cycles
    assign ref_tick = rose(ref_sync[2:1]);
    assign fb_tick  = rose(fb_sync[2:1]);

    // ========================================================
    // Divider counters
    logic [REF_W-1:0]       ref_load;
    logic [MAIN_W-1:0]      main_load;

    // Count words joined from their bytes. Nothing latches the pair, so
    // a running counter may pick up a mix of old and new bytes; hold it
    // in reset while both halves are rewritten.
    assign ref_load  = {ref_divider_high, ref_divider_low};
    assign main_load = {main_feedback_count_high, main_feedback_count_low};

    // Only the terminal pulses leave the block; running counts stay
    // inside. The swallow counter runs on feedback ticks by itself, a
    // simplified model of the two-counter feedback path.
    // Reference counter held by flopped hold
    div_counter #(
        .WIDTH      (REF_W)
    ) u_ref_counter (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .ce         (ce),
        .hold       (ref_in_reset),
        .tick       (ref_tick),
        .load_val   (ref_load),
        .count      (),
        .term       (ref_div_pulse)
    );

    div_counter #(
        .WIDTH      (SWALLOW_W)
    ) u_swallow_counter (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .ce         (ce),
        .hold       (fb_in_reset),
        .tick       (fb_tick),
        .load_val   (swallow_count),
        .count      (),
        .term       (swallow_pulse)
    );

    div_counter #(
        .WIDTH      (MAIN_W)
    ) u_main_counter (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .ce         (ce),
        .hold       (fb_in_reset),
        .tick       (fb_tick),
        .load_val   (main_load),
        .count      (),
        .term       (fb_div_pulse)
    );

endmodule

// ===== pll_divider_counter_config_properties.sv
// Port-level checks for the divider configuration block
`timescale 1ns/1ns
module pll_divider_counter_config_properties
    import pll_cfg_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              nrst,
    input wire logic              ce,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              reg_rvalid,
    input wire logic              ref_div_pulse,
    input wire logic              fb_div_pulse,
    input wire logic              pump_force_half,
    input wire logic              ref_in_reset,
    input wire logic              fb_in_reset,
    input wire logic              pll_active,
    input wire logic              sync_power_down,
    input wire logic              async_power_down
);
    // ========================================================
    // Write decodes; effects land two edges after the strobe
    wire logic w16 = ce && reg_wr && reg_addr == RST_PUMP_OFS;
    wire logic w10 = ce && reg_wr && reg_addr == PLL_CTRL_OFS;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_read_answer: assert property (
        $past(ce) |-> reg_rvalid == $past(reg_rd)) else $error("bad rvalid");
    a_rdata_hold: assert property (
        !reg_rvalid |-> $stable(reg_rdata)) else $error("rdata moved");
    a_ref_high_zero: assert property (
        ce && reg_rd && reg_addr == REF_HIGH_OFS |=> reg_rdata[7:6] == 2'h0)
        else $error("ref high spare bits set");
    a_main_high_zero: assert property (
        ce && reg_rd && reg_addr == MAIN_HIGH_OFS |=> reg_rdata[7:5] == 3'h0)
        else $error("main high spare bits set");
    a_pump_half: assert property (
        w16 ##1 ce [*2] |-> pump_force_half == $past(reg_wdata[7], 2))
        else $error("pump park wrong");
    a_ref_hold: assert property (
        w16 && (reg_wdata[6] || reg_wdata[4]) ##1 ce [*2] |-> ref_in_reset)
        else $error("ref not held");
    a_ref_run: assert property (
        w16 && !reg_wdata[6] && !reg_wdata[4] ##1 ce [*2] ##0 pll_active
        |-> !ref_in_reset) else $error("ref held wrongly");
    a_fb_hold: assert property (
        w16 && (reg_wdata[5] || reg_wdata[4]) ##1 ce [*2] |-> fb_in_reset)
        else $error("feedback not held");
    a_mode_normal: assert property (
        w10 ##1 ce [*2] |-> pll_active == ($past(reg_wdata[1:0], 2) == 2'h0))
        else $error("normal mode wrong");
    a_mode_down: assert property (
        w10 ##1 ce [*2] |-> async_power_down == ($past(reg_wdata[1:0], 2)
        == 2'h3) && sync_power_down == ($past(reg_wdata[1:0], 2) == 2'h1))
        else $error("power-down mode wrong");
    a_idle_holds: assert property (
        !pll_active |-> ref_in_reset && fb_in_reset) else $error("not held");
    a_no_ref_pulse: assert property (
        ref_in_reset && $past(ref_in_reset) && $past(ref_in_reset, 2)
        |-> !ref_div_pulse) else $error("ref pulse while held");
    a_no_fb_pulse: assert property (
        fb_in_reset && $past(fb_in_reset) && $past(fb_in_reset, 2)
        |-> !fb_div_pulse) else $error("fb pulse while held");
endmodule

// ===== pll_divider_counter_config_test.sv
// Self-checking bench for the divider configuration block
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module pll_divider_counter_config_test;
    import pll_cfg_pkg::*;
    logic              core_clk, nrst, ce, reg_wr, reg_rd, reg_rvalid;
    logic              ref_clk_pin, fb_clk_pin, ref_div_pulse, fb_div_pulse;
    logic              swallow_pulse, pump_force_half, ref_in_reset;
    logic              fb_in_reset, pll_active, sync_power_down;
    logic              async_power_down;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, d, v;
    int                failures, num_checks, n, p, pv[3];
    pll_divider_counter_config pll_divider_counter_config_inst (.core_clk,
        .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .reg_rvalid, .ref_clk_pin, .fb_clk_pin, .ref_div_pulse, .fb_div_pulse,
        .swallow_pulse, .pump_force_half, .ref_in_reset, .fb_in_reset,
        .pll_active, .sync_power_down, .async_power_down);
    // ========================================================
    // Clocks; pins toggle every 8 cycles, well under core_clk/2
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always begin
        repeat (8) @(negedge core_clk);
        ref_clk_pin = ~ref_clk_pin;
        fb_clk_pin = ~fb_clk_pin;
    end
    // ========================================================
    // Bus tasks and expectations
    task automatic wr(input logic [9:0] a, input logic [7:0] x);
        @(negedge core_clk);
        {reg_addr, reg_wdata, reg_wr} = {a, x, 1'b1};
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] x);
        @(negedge core_clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge core_clk);
        reg_rd = 1'b0;
        // Answer stands only in the cycle after the strobe edge
        `CHK(reg_rvalid, 1'b1)
        x = reg_rdata;
    endtask
    function automatic logic [7:0] msk(input logic [9:0] a);
        return (a == 10'h012 || a == 10'h013) ? 8'h3F :
               (a == 10'h015) ? 8'h1F : 8'hFF;
    endfunction
    function automatic logic [7:0] rstv(input logic [9:0] a);
        return a == 10'h011 ? 8'h01 : a == 10'h014 ? 8'h03 : 8'h00;
    endfunction
    function automatic logic pk(input int s);
        return s == 0 ? ref_div_pulse : s == 1 ? fb_div_pulse : swallow_pulse;
    endfunction
    // Cycles between two pulses of one counter
    task automatic gap(input int s, output int c);
        int k;
        k = 0;
        c = 1;
        while (pk(s) !== 1'b1 && k < 900) begin
            @(negedge core_clk);
            k++;
        end
        @(negedge core_clk);
        while (pk(s) !== 1'b1 && c < 900) begin
            @(negedge core_clk);
            c++;
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(4 * 40000);
        failures++;
        stop_test();
    end
    // ========================================================
    // Main sequence
    initial begin
        {nrst, ce, reg_wr, reg_rd, ref_clk_pin, fb_clk_pin} = 6'b010000;
        {reg_addr, reg_wdata} = '0;
        void'($urandom(64));
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        `CHK({ref_in_reset, fb_in_reset, sync_power_down}, 3'h7)
        `CHK({pump_force_half, pll_active, async_power_down}, 3'h0)
        for (int a = 10'h011; a <= 10'h016; a++) begin
            rd(a[9:0], d);
            `CHK(d, rstv(a[9:0]))
        end
        // to storage and spare bits, random data
        for (int i = 0; i < 15; i++) begin
            n = 10'h011 + i % 5;
            v = 8'($urandom);
            wr(n[9:0], v);
            rd(n[9:0], d);
            `CHK(d, v & msk(n[9:0]))
        end
        // A write with the clock enable low must not land
        wr(10'h011, v);
        ce = 1'b0;
        wr(10'h011, ~v);
        ce = 1'b1;
        rd(10'h011, d);
        `CHK(d, v)
        for (int m = 3; m >= 0; m--) begin
            wr(10'h010, {6'($urandom % 64), m[1:0]});
            @(negedge core_clk);
            `CHK({async_power_down, sync_power_down}, {m==3, m==1})
            `CHK(pll_active, m == 0)
        end
        foreach (v[i]) if (i >= 4) begin
            wr(10'h016, 8'h01 << i);
            @(negedge core_clk);
            `CHK(pump_force_half, i == 7)
            `CHK(ref_in_reset, i == 6 || i == 4)
            `CHK(fb_in_reset, i == 5 || i == 4)
        end
        // Program each ratio with all counters held, then release
        for (int s = 0; s < 3; s++) begin
            p = 2 + $urandom % 4;
            pv[s] = p;
            wr(10'h016, 8'h10);
            wr(s == 0 ? 10'h011 : s == 1 ? 10'h014 : 10'h013, p[7:0]);
            wr(s == 0 ? 10'h012 : 10'h015, 8'h00);
            wr(10'h016, 8'h00);
            gap(s, n);
            `CHK(n, p * 16)
        end
        // Reference held alone while the feedback side keeps dividing
        wr(10'h016, 8'h40);
        gap(0, n);
        `CHK(n, 900)
        gap(1, n);
        `CHK(n, pv[1] * 16)
        wr(10'h016, 8'h00);
        gap(0, n);
        `CHK(n, pv[0] * 16)
        stop_test();
    end
endmodule
bind pll_divider_counter_config pll_divider_counter_config_properties
    pll_divider_counter_config_properties_inst (.core_clk, .nrst, .ce,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .ref_div_pulse, .fb_div_pulse, .pump_force_half, .ref_in_reset,
    .fb_in_reset, .pll_active, .sync_power_down, .async_power_down);
